// ==== rtl/irq_time_base.sv ====
// Peripheral interrupt request logic with two-channel time-base generator
//
// Behaviour
// - Serial flag sets on byte received, byte sent, or address match.
// - Serial vectoring needs global, serial and group enables.
// - Serial service clears global enable and group flag, keeps serial flag.
// - Serial, time-out, UART, EEPROM, low-voltage sources feed shared group requests.
// - Each time-base channel sets its own flag on divider overflow.
// - Time-base vectoring needs global enable and that channel's enable.
// - No interrupt is requested while the return stack is full.
// - Time-base service clears that channel flag and global enable.
// - Control bit 7 stops both time-base channels at 0, runs at 1.
// - Control bit 6 picks sub-clock at 0, system clock over four at 1.
// - Bits 5:4 set channel 1 period to 2^12..2^15 input cycles.
// - Bits 2:0 set channel 0 period to 2^8..2^15 input cycles.
// - Control bit 3 drives slow crystal low-power start-up mode.
// - Time-out flag sets on counter overflow; vectors with global, own, group enables.
// - Time-out service clears only group flag and global enable.
// - UART raises request as an active-low pulse for six conditions.
// - UART vectoring needs global, group, UART enables; service clears global, group.
// - UART status flags are never cleared by interrupt service.
// - EEPROM flag sets at write end; vectors with global, own, group enables.
// - Low-voltage flag sets on low supply; vectors with global, own, group enables.
// - A group flag sets whenever any enabled member source raises its request.
// - Any flag rising wakes the device regardless of enables.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module irq_time_base (
  input wire logic clk,
  input wire logic arst_n,
  input wire irq_tb_pkg::reg_req_s reg_req,
  output logic [irq_tb_pkg::DATA_W-1:0] reg_rdata,
  input wire irq_tb_pkg::src_evt_s src_evt,
  input wire logic sub_clk_pin,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output irq_tb_pkg::vec_e irq_vector,
  output logic wake,
  output logic slow_crystal_low_power
);

  logic [irq_tb_pkg::NSRC-1:0] ctrl_r;
  logic [irq_tb_pkg::NSRC-1:0] ctrl_nxt;
  logic [irq_tb_pkg::NSRC-1:0] src_en_r;
  logic [irq_tb_pkg::NSRC-1:0] src_en_nxt;
  logic [irq_tb_pkg::NSRC-1:0] src_flag_r;
  logic [irq_tb_pkg::NSRC-1:0] src_flag_nxt;
  logic [irq_tb_pkg::NVEC-1:0] vec_flag_r;
  logic [irq_tb_pkg::NVEC-1:0] vec_flag_nxt;
  logic [irq_tb_pkg::DATA_W-1:0] tbc_r;
  logic [irq_tb_pkg::DATA_W-1:0] tbc_nxt;
  logic [irq_tb_pkg::DATA_W-1:0] rdata_r;
  logic [irq_tb_pkg::DATA_W-1:0] rdata_nxt;
  logic wake_r;
  logic wake_nxt;

  logic [irq_tb_pkg::TICK_CNT_W-1:0] tick_cnt_r;
  logic [irq_tb_pkg::TICK_CNT_W-1:0] tick_cnt_nxt;
  logic [irq_tb_pkg::SYS_DIV_W-1:0] sys_div_r;
  logic [irq_tb_pkg::SYS_DIV_W-1:0] sys_div_nxt;
  logic [2:0] sub_sync_r;
  logic [2:0] sub_sync_nxt;

  logic [irq_tb_pkg::NSRC-1:0] src_set;
  logic [1:0] grp_set;
  logic [1:0] tick_ovf;
  logic [3:0] tick_exp [2];
  logic [irq_tb_pkg::NVEC-1:0] pend;
  logic [irq_tb_pkg::NVEC-1:0] ack_clr;
  logic global_en;
  logic tick_run;
  logic tick_in;
  logic sys_tick;
  logic sub_edge;

  // Source events
  always_comb begin
    src_set = '0;
    src_set[irq_tb_pkg::SRC_SERIAL] = src_evt.serial_byte_done | src_evt.i2c_addr_match;
    src_set[irq_tb_pkg::SRC_TIMEOUT] = src_evt.bus_timeout_ovf;
    src_set[irq_tb_pkg::SRC_UART] = ~src_evt.serial_port_irq_n;
    src_set[irq_tb_pkg::SRC_NVM] = src_evt.nvm_write_end;
    src_set[irq_tb_pkg::SRC_LOWV] = src_evt.low_supply_detect;
  end

  // Enabled member requests funnel into the two shared group flags
  assign grp_set[0] = |(src_set & src_en_r & irq_tb_pkg::GROUP0_MEMBERS);
  assign grp_set[1] = |(src_set & src_en_r & irq_tb_pkg::GROUP1_MEMBERS);

  assign global_en = ctrl_r[irq_tb_pkg::CTRL_GLOBAL];

  // Pending requests: flag and own enable; global enable gates irq_req
  always_comb begin
    pend[irq_tb_pkg::VF_GRP0] = vec_flag_r[irq_tb_pkg::VF_GRP0]
      & ctrl_r[irq_tb_pkg::CTRL_GRP0_EN];
    pend[irq_tb_pkg::VF_GRP1] = vec_flag_r[irq_tb_pkg::VF_GRP1]
      & ctrl_r[irq_tb_pkg::CTRL_GRP1_EN];
    pend[irq_tb_pkg::VF_TICK0] = vec_flag_r[irq_tb_pkg::VF_TICK0]
      & ctrl_r[irq_tb_pkg::CTRL_TICK0_EN];
    pend[irq_tb_pkg::VF_TICK1] = vec_flag_r[irq_tb_pkg::VF_TICK1]
      & ctrl_r[irq_tb_pkg::CTRL_TICK1_EN];
  end

  assign irq_req = global_en & ~stack_full & (|pend);

  // Fixed priority among pending vectors
  always_comb begin
    if (pend[irq_tb_pkg::VF_GRP0]) begin
      irq_vector = irq_tb_pkg::VEC_GRP0;
    end else if (pend[irq_tb_pkg::VF_GRP1]) begin
      irq_vector = irq_tb_pkg::VEC_GRP1;
    end else if (pend[irq_tb_pkg::VF_TICK0]) begin
      irq_vector = irq_tb_pkg::VEC_TICK0;
    end else begin
      irq_vector = irq_tb_pkg::VEC_TICK1;
    end
  end

  // Flag cleared by the core taking a vector; source flags are left alone
  always_comb begin
    ack_clr = '0;
    if (irq_ack) begin
      case (irq_vector)
        irq_tb_pkg::VEC_GRP0: ack_clr[irq_tb_pkg::VF_GRP0] = 1'b1;
        irq_tb_pkg::VEC_GRP1: ack_clr[irq_tb_pkg::VF_GRP1] = 1'b1;
        irq_tb_pkg::VEC_TICK0: ack_clr[irq_tb_pkg::VF_TICK0] = 1'b1;
        irq_tb_pkg::VEC_TICK1: ack_clr[irq_tb_pkg::VF_TICK1] = 1'b1;
        default: ack_clr = '0;
      endcase
    end
  end

  // Register file next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    src_en_nxt = src_en_r;
    tbc_nxt = tbc_r;
    src_flag_nxt = src_flag_r;
    vec_flag_nxt = vec_flag_r;
    rdata_nxt = '0;
    if (reg_req.wr) begin
      case (reg_req.addr)
        irq_tb_pkg::OFS_CTRL: ctrl_nxt = reg_req.wdata[irq_tb_pkg::NSRC-1:0];
        irq_tb_pkg::OFS_SRC_EN: src_en_nxt = reg_req.wdata[irq_tb_pkg::NSRC-1:0];
        irq_tb_pkg::OFS_SRC_FLAG: src_flag_nxt = src_flag_r
          & ~reg_req.wdata[irq_tb_pkg::NSRC-1:0];
        irq_tb_pkg::OFS_VEC_FLAG: vec_flag_nxt = vec_flag_r
          & ~reg_req.wdata[irq_tb_pkg::NVEC-1:0];
        irq_tb_pkg::OFS_TBC: tbc_nxt = reg_req.wdata;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (irq_ack) begin
      ctrl_nxt[irq_tb_pkg::CTRL_GLOBAL] = 1'b0;
    end
    if (irq_return) begin
      ctrl_nxt[irq_tb_pkg::CTRL_GLOBAL] = 1'b1;
    end
    // Hardware sets win over any clear in the same cycle
    src_flag_nxt = (src_flag_nxt | src_set) & ~irq_tb_pkg::UART_MASK;
    vec_flag_nxt = (vec_flag_nxt & ~ack_clr) | {tick_ovf, grp_set};
    if (reg_req.rd) begin
      case (reg_req.addr)
        irq_tb_pkg::OFS_CTRL: rdata_nxt = {3'h0, ctrl_r};
        irq_tb_pkg::OFS_SRC_EN: rdata_nxt = {3'h0, src_en_r};
        irq_tb_pkg::OFS_SRC_FLAG: rdata_nxt = {3'h0, src_flag_r};
        irq_tb_pkg::OFS_VEC_FLAG: rdata_nxt = {4'h0, vec_flag_r};
        irq_tb_pkg::OFS_TBC: rdata_nxt = tbc_r;
        default: rdata_nxt = '0;
      endcase
    end
    wake_nxt = (|(src_flag_nxt & ~src_flag_r)) | (|(vec_flag_nxt & ~vec_flag_r))
      | src_set[irq_tb_pkg::SRC_UART];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= irq_tb_pkg::CTRL_RESET;
      src_en_r <= irq_tb_pkg::SRC_RESET;
      src_flag_r <= irq_tb_pkg::SRC_RESET;
      vec_flag_r <= irq_tb_pkg::VF_RESET;
      tbc_r <= irq_tb_pkg::TBC_RESET;
      rdata_r <= '0;
      wake_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      src_en_r <= src_en_nxt;
      src_flag_r <= src_flag_nxt;
      vec_flag_r <= vec_flag_nxt;
      tbc_r <= tbc_nxt;
      rdata_r <= rdata_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign wake = wake_r;
  assign slow_crystal_low_power = tbc_r[irq_tb_pkg::TBC_SLOW_CRYSTAL_LOW_POWER];

  // Time-base input clock and divider chain
  assign tick_run = tbc_r[irq_tb_pkg::TBC_RUN];
  assign sub_edge = sub_sync_r[1] & ~sub_sync_r[2];
  assign sys_tick = (sys_div_r == irq_tb_pkg::SYS_DIV_LAST);
  assign tick_in = tick_run & (tbc_r[irq_tb_pkg::TBC_CLKSEL] ? sys_tick : sub_edge);

  always_comb begin
    sub_sync_nxt = {sub_sync_r[1:0], sub_clk_pin};
    if (!tick_run) begin
      sys_div_nxt = irq_tb_pkg::SYS_DIV_ZERO;
      tick_cnt_nxt = irq_tb_pkg::TICK_ZERO;
    end else begin
      sys_div_nxt = 2'(sys_div_r + 2'h1);
      tick_cnt_nxt = tick_in ? 15'(tick_cnt_r + 15'h0001) : tick_cnt_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_sync_r <= '0;
      sys_div_r <= irq_tb_pkg::SYS_DIV_ZERO;
      tick_cnt_r <= irq_tb_pkg::TICK_ZERO;
    end else begin
      sub_sync_r <= sub_sync_nxt;
      sys_div_r <= sys_div_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  assign tick_exp[0] = irq_tb_pkg::TICK0_BASE_EXP
    + {1'b0, tbc_r[irq_tb_pkg::TBC_P0_HI:irq_tb_pkg::TBC_P0_LO]};
  assign tick_exp[1] = irq_tb_pkg::TICK1_BASE_EXP
    + {2'h0, tbc_r[irq_tb_pkg::TBC_P1_HI:irq_tb_pkg::TBC_P1_LO]};

  // A channel overflows when the low bits of the chain roll over
  for (genvar ch = 0; ch < 2; ch++) begin : g_tick
    logic [irq_tb_pkg::TICK_CNT_W-1:0] mask;
    assign mask = irq_tb_pkg::TICK_FULL >> (irq_tb_pkg::TICK_EXP_MAX - tick_exp[ch]);
    assign tick_ovf[ch] = tick_in & ((tick_cnt_r & mask) == mask);
  end

  property p_serial_set;
    @(posedge clk) disable iff (!arst_n)
    (src_evt.serial_byte_done || src_evt.i2c_addr_match)
      |=> src_flag_r[irq_tb_pkg::SRC_SERIAL];
  endproperty
  a_serial_set: assert property (p_serial_set) else $error("serial flag not set");

  property p_req_needs_enables;
    @(posedge clk) disable iff (!arst_n)
    (irq_req && irq_vector == irq_tb_pkg::VEC_GRP0)
      |-> global_en && ctrl_r[irq_tb_pkg::CTRL_GRP0_EN];
  endproperty
  a_req_needs_enables: assert property (p_req_needs_enables)
    else $error("group request without enables");

  property p_group_ack_keeps_source;
    @(posedge clk) disable iff (!arst_n)
    (irq_ack && irq_vector == irq_tb_pkg::VEC_GRP0 && !irq_return && !grp_set[0]
      && src_flag_r[irq_tb_pkg::SRC_SERIAL] && !reg_req.wr)
      |=> !global_en && !vec_flag_r[irq_tb_pkg::VF_GRP0]
        && src_flag_r[irq_tb_pkg::SRC_SERIAL];
  endproperty
  a_group_ack_keeps_source: assert property (p_group_ack_keeps_source)
    else $error("group service cleared wrong flags");

  property p_tick_set;
    @(posedge clk) disable iff (!arst_n)
    tick_ovf[0] |=> vec_flag_r[irq_tb_pkg::VF_TICK0];
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("tick0 flag not set");

  property p_stack_full;
    @(posedge clk) disable iff (!arst_n)
    stack_full |-> !irq_req;
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("request while stack full");

  property p_tick_ack_clear;
    @(posedge clk) disable iff (!arst_n)
    (irq_ack && irq_vector == irq_tb_pkg::VEC_TICK0 && !tick_ovf[0] && !irq_return)
      |=> !vec_flag_r[irq_tb_pkg::VF_TICK0] && !global_en;
  endproperty
  a_tick_ack_clear: assert property (p_tick_ack_clear)
    else $error("tick0 service did not clear");

  property p_stopped;
    @(posedge clk) disable iff (!arst_n)
    !tick_run |=> (tick_cnt_r == irq_tb_pkg::TICK_ZERO) && !tick_ovf[0] && !tick_ovf[1];
  endproperty
  a_stopped: assert property (p_stopped) else $error("time base runs while off");

  property p_sys_div;
    @(posedge clk) disable iff (!arst_n)
    (tick_in && tbc_r[irq_tb_pkg::TBC_CLKSEL] && tick_run && $stable(tbc_r))
      |=> (!(tick_in && tbc_r[irq_tb_pkg::TBC_CLKSEL]))[*3];
  endproperty
  a_sys_div: assert property (p_sys_div) else $error("system tick faster than four");

  property p_group_set;
    @(posedge clk) disable iff (!arst_n)
    grp_set[1] |=> vec_flag_r[irq_tb_pkg::VF_GRP1];
  endproperty
  a_group_set: assert property (p_group_set) else $error("group flag not set");

  property p_wake;
    @(posedge clk) disable iff (!arst_n)
    $rose(vec_flag_r[irq_tb_pkg::VF_TICK1]) |-> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on rising flag");

  property p_priority;
    @(posedge clk) disable iff (!arst_n)
    (irq_req && pend[irq_tb_pkg::VF_GRP1] && !pend[irq_tb_pkg::VF_GRP0])
      |-> irq_vector == irq_tb_pkg::VEC_GRP1;
  endproperty
  a_priority: assert property (p_priority) else $error("priority order broken");

  property p_timeout_set;
    @(posedge clk) disable iff (!arst_n)
    src_evt.bus_timeout_ovf |=> src_flag_r[irq_tb_pkg::SRC_TIMEOUT];
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("time-out flag not set");

  property p_uart_group;
    @(posedge clk) disable iff (!arst_n)
    (!src_evt.serial_port_irq_n && src_en_r[irq_tb_pkg::SRC_UART])
      |=> vec_flag_r[irq_tb_pkg::VF_GRP0];
  endproperty
  a_uart_group: assert property (p_uart_group)
    else $error("serial port request lost");

  property p_nvm_group;
    @(posedge clk) disable iff (!arst_n)
    (src_evt.nvm_write_end && src_en_r[irq_tb_pkg::SRC_NVM])
      |=> src_flag_r[irq_tb_pkg::SRC_NVM] && vec_flag_r[irq_tb_pkg::VF_GRP1];
  endproperty
  a_nvm_group: assert property (p_nvm_group)
    else $error("write-done request lost");

  property p_low_supply_set;
    @(posedge clk) disable iff (!arst_n)
    src_evt.low_supply_detect |=> src_flag_r[irq_tb_pkg::SRC_LOWV];
  endproperty
  a_low_supply_set: assert property (p_low_supply_set)
    else $error("low supply flag not set");

  property p_tick1_gate;
    @(posedge clk) disable iff (!arst_n)
    (irq_req && irq_vector == irq_tb_pkg::VEC_TICK1)
      |-> global_en && ctrl_r[irq_tb_pkg::CTRL_TICK1_EN];
  endproperty
  a_tick1_gate: assert property (p_tick1_gate)
    else $error("tick1 request without enables");

  property p_tick1_set;
    @(posedge clk) disable iff (!arst_n)
    tick_ovf[1] |=> vec_flag_r[irq_tb_pkg::VF_TICK1];
  endproperty
  a_tick1_set: assert property (p_tick1_set) else $error("tick1 flag not set");

  property p_crystal_bit;
    @(posedge clk) disable iff (!arst_n)
    (reg_req.wr && reg_req.addr == irq_tb_pkg::OFS_TBC)
      |=> slow_crystal_low_power == $past(reg_req.wdata[irq_tb_pkg::TBC_SLOW_CRYSTAL_LOW_POWER]);
  endproperty
  a_crystal_bit: assert property (p_crystal_bit)
    else $error("crystal mode bit not applied");

  property p_uart_wake;
    @(posedge clk) disable iff (!arst_n)
    !src_evt.serial_port_irq_n |=> wake;
  endproperty
  a_uart_wake: assert property (p_uart_wake)
    else $error("no wake on serial port request");

endmodule

// ==== rtl/irq_tb_pkg.sv ====
// Constants, types and register map of the peripheral interrupt and time-base block
package irq_tb_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NSRC = 5;
  localparam int NVEC = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_SRC_EN = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_VEC_FLAG = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_TBC = 3'h4;

  // Control register bits
  localparam int CTRL_GLOBAL = 0;
  localparam int CTRL_GRP0_EN = 1;
  localparam int CTRL_GRP1_EN = 2;
  localparam int CTRL_TICK0_EN = 3;
  localparam int CTRL_TICK1_EN = 4;
  localparam logic [NSRC-1:0] CTRL_RESET = 5'h00;

  // Source positions in the enable and flag registers
  localparam int SRC_SERIAL = 0;
  localparam int SRC_TIMEOUT = 1;
  localparam int SRC_UART = 2;
  localparam int SRC_NVM = 3;
  localparam int SRC_LOWV = 4;
  localparam logic [NSRC-1:0] SRC_RESET = 5'h00;
  localparam logic [NSRC-1:0] UART_MASK = 5'h04;
  localparam logic [NSRC-1:0] GROUP0_MEMBERS = 5'h07;
  localparam logic [NSRC-1:0] GROUP1_MEMBERS = 5'h18;

  // Vector flag register bits
  localparam int VF_GRP0 = 0;
  localparam int VF_GRP1 = 1;
  localparam int VF_TICK0 = 2;
  localparam int VF_TICK1 = 3;
  localparam logic [NVEC-1:0] VF_RESET = 4'h0;

  // Time-base control fields
  localparam int TBC_RUN = 7;
  localparam int TBC_CLKSEL = 6;
  localparam int TBC_P1_HI = 5;
  localparam int TBC_P1_LO = 4;
  localparam int TBC_SLOW_CRYSTAL_LOW_POWER = 3;
  localparam int TBC_P0_HI = 2;
  localparam int TBC_P0_LO = 0;
  localparam logic [DATA_W-1:0] TBC_RESET = 8'h37;

  localparam int TICK_CNT_W = 15;
  localparam logic [3:0] TICK_EXP_MAX = 4'hF;
  localparam logic [3:0] TICK0_BASE_EXP = 4'h8;
  localparam logic [3:0] TICK1_BASE_EXP = 4'hC;
  localparam logic [TICK_CNT_W-1:0] TICK_FULL = 15'h7FFF;
  localparam logic [TICK_CNT_W-1:0] TICK_ZERO = 15'h0000;
  localparam int SYS_DIV_W = 2;
  localparam logic [SYS_DIV_W-1:0] SYS_DIV_LAST = 2'h3;
  localparam logic [SYS_DIV_W-1:0] SYS_DIV_ZERO = 2'h0;

  typedef enum logic [1:0] {
    VEC_GRP0 = 2'b00,
    VEC_GRP1 = 2'b01,
    VEC_TICK0 = 2'b11,
    VEC_TICK1 = 2'b10
  } vec_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic serial_byte_done;
    logic i2c_addr_match;
    logic bus_timeout_ovf;
    logic serial_port_irq_n;
    logic nvm_write_end;
    logic low_supply_detect;
  } src_evt_s;
endpackage

// ==== tb/core_model.sv ====
// Processor core model: takes offered vectors and returns from service later
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire irq_tb_pkg::vec_e irq_vector,
  output logic irq_ack,
  output logic irq_return,
  output irq_tb_pkg::vec_e last_vec,
  output logic [31:0] n_acks,
  output logic [31:0] ack_gap
);
  logic [31:0] cyc;
  logic [31:0] ack_cyc;
  logic [4:0] ret_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      last_vec <= irq_tb_pkg::VEC_GRP0;
      n_acks <= 32'h0;
      ack_gap <= 32'h0;
      cyc <= 32'h0;
      ack_cyc <= 32'h0;
      ret_cnt <= 5'h00;
    end else begin
      cyc <= cyc + 32'h1;
      // Acknowledge only what is offered, one pulse per offer
      irq_ack <= irq_req && !irq_ack;
      // Service routine ends with a return that re-arms the global enable
      irq_return <= (ret_cnt == 5'h01);
      if (ret_cnt != 5'h00) begin
        ret_cnt <= ret_cnt - 5'h01;
      end
      if (irq_ack && irq_req) begin
        n_acks <= n_acks + 32'h1;
        last_vec <= irq_vector;
        ack_gap <= cyc - ack_cyc;
        ack_cyc <= cyc;
        ret_cnt <= 5'h14;
      end
    end
  end
endmodule

// ==== tb/mcu_peripheral_interrupt_and_time_base_tb.sv ====
// Self-checking bench of the interrupt request and time-base block
`timescale 1ns/1ps
module mcu_peripheral_interrupt_and_time_base_tb;
  logic clk;
  logic arst_n;
  irq_tb_pkg::reg_req_s rq;
  logic [7:0] reg_rdata;
  irq_tb_pkg::src_evt_s ev;
  logic sub_clk = 1'b0;
  logic sub_en;
  logic [1:0] sc_cnt = 2'h0;
  logic stack_full;
  logic irq_ack;
  logic irq_return;
  logic irq_req;
  irq_tb_pkg::vec_e irq_vector;
  irq_tb_pkg::vec_e last_vec;
  logic wake;
  logic lp;
  logic [31:0] n_acks;
  logic [31:0] ack_gap;
  logic [31:0] n_wake = 32'h0;
  int fails;
  int n_compared;
  int cycles = 0;
  int seed;
  localparam logic [5:0] EV_IDLE = 6'h04;

  irq_time_base DUT (.clk(clk), .arst_n(arst_n), .reg_req(rq), .reg_rdata(reg_rdata),
    .src_evt(ev), .sub_clk_pin(sub_clk), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector), .wake(wake),
    .slow_crystal_low_power(lp));
  core_model core (.clk(clk), .arst_n(arst_n), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .irq_return(irq_return), .last_vec(last_vec), .n_acks(n_acks),
    .ack_gap(ack_gap));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) begin
      n_wake <= n_wake + 32'h1;
    end
    // Sub-clock toggles every 4 system clocks, period 8
    if (sub_en) begin
      sc_cnt <= sc_cnt + 2'h1;
      if (sc_cnt == 2'h3) begin
        sub_clk <= ~sub_clk;
      end
    end
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    rq.addr <= a;
    rq.wdata <= d;
    rq.wr <= 1'b1;
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask

  task automatic chkr(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rq.addr <= a;
    rq.rd <= 1'b1;
    @(posedge clk);
    rq.rd <= 1'b0;
    #1;
    chk(nm, 32'(e), 32'(reg_rdata));
  endtask

  task automatic wait_acks(input int n);
    logic [31:0] base;
    int cnt;
    base = n_acks;
    cnt = 0;
    while (n_acks - base < 32'(n) && cnt < 40000) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= 40000) begin
      fails++;
      conclude();
    end
  endtask

  function automatic int sbit(input int k);
    return (k < 2) ? 0 : k - 1;
  endfunction

  function automatic logic [31:0] tick_gap(input int div, input int e);
    return 32'(div) << e;
  endfunction

  initial begin
    int k;
    int cs;
    int e;
    logic sf;
    logic vect;
    logic grp;
    logic [7:0] cw;
    logic [31:0] a0;
    logic [31:0] w0;
    seed = 52127;
    arst_n = 1'b0;
    rq = '0;
    ev = irq_tb_pkg::src_evt_s'(EV_IDLE);
    sub_en = 1'b0;
    stack_full = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    chkr("tbc_reset", irq_tb_pkg::OFS_TBC, 8'h37);
    chkr("ctrl_reset", irq_tb_pkg::OFS_CTRL, 8'h00);
    chkr("src_en_reset", irq_tb_pkg::OFS_SRC_EN, 8'h00);
    chkr("unmapped", 3'h5, 8'h00);
    chk("crystal_lp", 32'h0, 32'(lp));
    for (int i = 0; i < 18; i++) begin
      k = i % 6;
      cs = (i < 6) ? 0 : ($random(seed) & 3);
      sf = (i == 1) || (i >= 6 && ($random(seed) & 3) == 0);
      grp = (k >= 4);
      vect = (cs == 0) && !sf;
      cw = (cs == 1) ? 8'h06 : ((cs == 2) ? 8'h01 : 8'h07);
      wr(irq_tb_pkg::OFS_SRC_EN, (cs == 3) ? (8'h1F ^ (8'h01 << sbit(k))) : 8'h1F);
      wr(irq_tb_pkg::OFS_CTRL, cw);
      stack_full <= sf;
      a0 = n_acks;
      w0 = n_wake;
      @(posedge clk);
      ev <= irq_tb_pkg::src_evt_s'(EV_IDLE ^ (6'h20 >> k));
      @(posedge clk);
      ev <= irq_tb_pkg::src_evt_s'(EV_IDLE);
      repeat (3) @(posedge clk);
      chk("acks", a0 + 32'(vect), n_acks);
      if (vect) begin
        chk("vector", 32'(grp ? irq_tb_pkg::VEC_GRP1 : irq_tb_pkg::VEC_GRP0),
          32'(last_vec));
      end
      chk("wake", w0 + 32'h1, n_wake);
      chkr("src_flag", irq_tb_pkg::OFS_SRC_FLAG,
        (k == 3) ? 8'h00 : (8'h01 << sbit(k)));
      chkr("vec_flag", irq_tb_pkg::OFS_VEC_FLAG,
        (cs != 3 && !vect) ? (grp ? 8'h02 : 8'h01) : 8'h00);
      chkr("ctrl", irq_tb_pkg::OFS_CTRL, vect ? (cw & 8'hFE) : cw);
      wr(irq_tb_pkg::OFS_SRC_FLAG, 8'h1F);
      wr(irq_tb_pkg::OFS_VEC_FLAG, 8'h0F);
      chkr("src_clear", irq_tb_pkg::OFS_SRC_FLAG, 8'h00);
      stack_full <= 1'b0;
      repeat (20) @(posedge clk);
    end
    // Two groups pending together behind a full stack
    wr(irq_tb_pkg::OFS_CTRL, 8'h07);
    stack_full <= 1'b1;
    a0 = n_acks;
    @(posedge clk);
    ev <= irq_tb_pkg::src_evt_s'(EV_IDLE | 6'h22);
    @(posedge clk);
    ev <= irq_tb_pkg::src_evt_s'(EV_IDLE);
    stack_full <= 1'b0;
    repeat (6) @(posedge clk);
    chk("prio_first", 32'(irq_tb_pkg::VEC_GRP0), 32'(last_vec));
    repeat (25) @(posedge clk);
    chk("prio_second", 32'(irq_tb_pkg::VEC_GRP1), 32'(last_vec));
    chk("prio_acks", a0 + 32'h2, n_acks);
    wr(irq_tb_pkg::OFS_SRC_FLAG, 8'h1F);
    // Tick 0 on the system clock over four
    e = $random(seed) & 3;
    wr(irq_tb_pkg::OFS_CTRL, 8'h09);
    wr(irq_tb_pkg::OFS_TBC, 8'hF0 | 8'(e));
    wait_acks(3);
    chk("tick0_gap", tick_gap(4, 8 + e), ack_gap);
    chk("tick0_vec", 32'(irq_tb_pkg::VEC_TICK0), 32'(last_vec));
    chkr("tick0_flag", irq_tb_pkg::OFS_VEC_FLAG, 8'h00);
    chkr("global_cleared", irq_tb_pkg::OFS_CTRL, 8'h08);
    // Tick 0 on the sub-clock
    wr(irq_tb_pkg::OFS_TBC, 8'h00);
    sub_en <= 1'b1;
    wr(irq_tb_pkg::OFS_TBC, 8'h80);
    wait_acks(3);
    chk("sub_gap", tick_gap(8, 8), ack_gap);
    sub_en <= 1'b0;
    // Tick 1 at its shortest period
    wr(irq_tb_pkg::OFS_TBC, 8'h00);
    wr(irq_tb_pkg::OFS_CTRL, 8'h11);
    wr(irq_tb_pkg::OFS_VEC_FLAG, 8'h0F);
    wr(irq_tb_pkg::OFS_TBC, 8'hC0);
    wait_acks(2);
    chk("tick1_gap", tick_gap(4, 12), ack_gap);
    chk("tick1_vec", 32'(irq_tb_pkg::VEC_TICK1), 32'(last_vec));
    // Stopped time base and crystal mode bit
    wr(irq_tb_pkg::OFS_TBC, 8'h48);
    wr(irq_tb_pkg::OFS_VEC_FLAG, 8'h0F);
    wr(irq_tb_pkg::OFS_CTRL, 8'h19);
    a0 = n_acks;
    repeat (3000) @(posedge clk);
    chk("stopped", a0, n_acks);
    chk("crystal_lp", 32'h1, 32'(lp));
    chkr("tbc_rw", irq_tb_pkg::OFS_TBC, 8'h48);
    conclude();
  end
endmodule
